/* src/rst_trap_pkg.sv */
// package: constants and carrier types for the reset, trap and power-down control
package rst_trap_pkg;
   localparam int    CLK_PERIOD_PS    = 8000;
   localparam int    SPIKE_IGNORE_PS  = 10000;
   localparam int    SAFE_ACCEPT_PS   = 100000;
   // shortest accepted low pulse: at most the safe figure, rounded down, at least one cycle
   localparam int    ACCEPT_CYC_RAW   = SAFE_ACCEPT_PS / CLK_PERIOD_PS;
   localparam int    ACCEPT_CYC       = (ACCEPT_CYC_RAW < 1) ? 1 : ACCEPT_CYC_RAW;
   // anything shorter than the ignore figure, rounded up, is always rejected
   localparam int    IGNORE_CYC       = (SPIKE_IGNORE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int    FILT_W           = 5;
   localparam logic [FILT_W-1:0] FILT_LIMIT = FILT_W'(ACCEPT_CYC);
   localparam logic [FILT_W-1:0] FILT_ZERO  = 5'h00;
   localparam int    SYNC_STAGES      = 2;

   typedef struct packed {
      logic reset_req;
      logic trap_req;
      logic power_down;
      logic pd_ignored;
   } ctrl_out_s;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_RESET = 2'b01,
      ST_PDOWN = 2'b10
   } pm_state_e;
endpackage : rst_trap_pkg

/* src/pin_sync.sv */
// two-stage synchroniser for one asynchronous pin
`timescale 1ns/1ps
module pin_sync (
   input  wire logic clk_sys_i,
   input  wire logic resetn_i,
   input  wire logic pin_i,
   output logic      pin_sync_o
);
   import rst_trap_pkg::*;

   logic [SYNC_STAGES-1:0] stage_reg;
   logic [SYNC_STAGES-1:0] stage_next;

   always_comb begin
      stage_next = {stage_reg[SYNC_STAGES-2:0], pin_i};
   end

   // idle level of both pins is high
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stage_reg <= '1;
      end else begin
         stage_reg <= stage_next;
      end
   end

   assign pin_sync_o = stage_reg[SYNC_STAGES-1];
endmodule // pin_sync

/* src/reset_trap_powerdown_ctrl.sv */
// reset qualifier, urgent trap edge detector and power-down gate
// How it works
// - a low reset pin level seen while the clock runs puts the device in reset.
// - low pulses under 10 ns are dropped and those over 100 ns are always accepted.
// - a falling edge on the urgent trap pin requests the non-maskable trap, except while the device is held in reset.
// - the power-down instruction with the trap pin low enters power-down from run, unless reset is taken in the same cycle.
// - the power-down instruction with the trap pin high is ignored.
`timescale 1ns/1ps
module reset_trap_powerdown_ctrl (
   input  wire logic                  clk_sys_i,
   input  wire logic                  resetn_i,
   input  wire logic                  reset_input_low_i,
   input  wire logic                  urgent_trap_n_i,
   input  wire logic                  power_down_instruction_i,
   input  wire logic                  wakeup_i,
   output rst_trap_pkg::ctrl_out_s    ctrl_o
);
   import rst_trap_pkg::*;

   logic              rst_s;
   logic              trap_s;
   logic              trap_d_reg;
   logic              trap_d_next;
   logic [FILT_W-1:0] low_cnt_reg;
   logic [FILT_W-1:0] low_cnt_next;
   pm_state_e         state_reg;
   pm_state_e         state_next;
   ctrl_out_s         out_reg;
   ctrl_out_s         out_next;

   // full low time reached: shared by the state logic and the checks
   function automatic logic cnt_full(input logic [FILT_W-1:0] cnt);
      return (cnt == FILT_LIMIT);
   endfunction

   pin_sync u_rst_sync (
      .clk_sys_i  (clk_sys_i),
      .resetn_i   (resetn_i),
      .pin_i      (reset_input_low_i),
      .pin_sync_o (rst_s)
   );
   pin_sync u_trap_sync (
      .clk_sys_i  (clk_sys_i),
      .resetn_i   (resetn_i),
      .pin_i      (urgent_trap_n_i),
      .pin_sync_o (trap_s)
   );

   always_comb begin
      trap_d_next  = trap_s;
      if (rst_s) begin
         low_cnt_next = FILT_ZERO;
      end else if (low_cnt_reg != FILT_LIMIT) begin
         low_cnt_next = low_cnt_reg + 5'h01;
      end else begin
         low_cnt_next = low_cnt_reg;
      end
      state_next = state_reg;
      out_next   = '0;
      case (state_reg)
         ST_RUN: begin
            if (power_down_instruction_i && !trap_s) begin
               state_next = ST_PDOWN;
            end else if (power_down_instruction_i) begin
               out_next.pd_ignored = 1'b1;
            end
         end
         ST_PDOWN: begin
            if (wakeup_i) begin
               state_next = ST_RUN;
            end
         end
         ST_RESET: begin
            if (rst_s) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
      if (cnt_full(low_cnt_next)) begin
         state_next = ST_RESET;
      end
      // falling edge gives a trap pulse
      out_next.trap_req   = trap_d_reg && !trap_s && (state_next != ST_RESET);
      out_next.reset_req  = (state_next == ST_RESET);
      out_next.power_down = (state_next == ST_PDOWN);
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         trap_d_reg  <= 1'b1;
         low_cnt_reg <= FILT_ZERO;
         state_reg   <= ST_RUN;
         out_reg     <= '0;
      end else begin
         trap_d_reg  <= trap_d_next;
         low_cnt_reg <= low_cnt_next;
         state_reg   <= state_next;
         out_reg     <= out_next;
      end
   end

   assign ctrl_o = out_reg;

   // reset only after the full low time
   reset_after_low_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      $rose(out_reg.reset_req) |-> $past(low_cnt_reg) == FILT_LIMIT - 5'h01)
      else $error("reset raised without full low time");
   reset_held_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (low_cnt_reg == FILT_LIMIT && !rst_s) |=> out_reg.reset_req)
      else $error("reset dropped while pin low");
   spike_drop_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_reg == ST_RUN && rst_s ##1 !rst_s ##1 rst_s) |=> !out_reg.reset_req)
      else $error("spike caused reset");
   trap_edge_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (out_reg.trap_req) |-> $past(trap_d_reg) && !$past(trap_s))
      else $error("trap without falling edge");
   trap_pulse_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      out_reg.trap_req |=> !out_reg.trap_req)
      else $error("trap pulse too long");
   pd_enter_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_reg == ST_RUN && power_down_instruction_i && !trap_s && low_cnt_next != FILT_LIMIT)
      |=> out_reg.power_down)
      else $error("power-down not entered");
   pd_ignore_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_reg == ST_RUN && power_down_instruction_i && trap_s && low_cnt_next != FILT_LIMIT)
      |=> !out_reg.power_down && out_reg.pd_ignored)
      else $error("power-down taken with trap high");
   sync_delay_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      rst_s == $past(reset_input_low_i, 2))
      else $error("reset sync depth wrong");

   trap_sync_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      trap_s == $past(urgent_trap_n_i, 2))
      else $error("trap sync depth wrong");

   cnt_clear_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      rst_s |=> low_cnt_reg == FILT_ZERO)
      else $error("low count not cleared");

   cnt_step_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (!rst_s && !cnt_full(low_cnt_reg))
      |=> low_cnt_reg == $past(low_cnt_reg) + 5'h01)
      else $error("low count did not step");

   cnt_sat_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (!rst_s && cnt_full(low_cnt_reg))
      |=> cnt_full(low_cnt_reg))
      else $error("low count wrapped");

   reset_release_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (out_reg.reset_req && rst_s)
      |=> !out_reg.reset_req)
      else $error("reset kept after pin high");

   reset_beats_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      cnt_full(low_cnt_next)
      |=> out_reg.reset_req && !out_reg.power_down && !out_reg.trap_req)
      else $error("reset lost priority");

   state_legal_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      state_reg inside {ST_RUN, ST_RESET, ST_PDOWN})
      else $error("illegal state code");

   trap_masked_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_reg == ST_RESET && !rst_s)
      |=> !out_reg.trap_req)
      else $error("trap reported in reset");

   pd_hold_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (out_reg.power_down && !wakeup_i && !cnt_full(low_cnt_next))
      |=> out_reg.power_down)
      else $error("power-down left early");

   pd_exit_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (out_reg.power_down && wakeup_i && !cnt_full(low_cnt_next))
      |=> !out_reg.power_down)
      else $error("power-down not left");

   pd_only_run_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_reg != ST_RUN)
      |=> !out_reg.pd_ignored)
      else $error("ignore flag outside run");

   reset_seen_c: cover property (@(posedge clk_sys_i) $rose(out_reg.reset_req));
   trap_seen_c:  cover property (@(posedge clk_sys_i) out_reg.trap_req);
   pd_seen_c:    cover property (@(posedge clk_sys_i) $rose(out_reg.power_down));
   pd_skip_c:    cover property (@(posedge clk_sys_i) out_reg.pd_ignored);
   pd_wake_c:    cover property (@(posedge clk_sys_i) $fell(out_reg.power_down));
endmodule // reset_trap_powerdown_ctrl

/* dv/ext_src.sv */
// partner model: board reset source and urgent trap source
`timescale 1ns/1ps
module ext_src (
   input  wire logic clk_sys_i,
   output logic      rst_pin_o,
   output logic      trap_pin_o
);
   // pins idle high, as pulled up on the board
   initial begin
      rst_pin_o  = 1'h1;
      trap_pin_o = 1'h1;
   end
   // hold reset low for a set time
   task automatic hold_reset(input int cyc);
      @(posedge clk_sys_i) #1 rst_pin_o = 1'h0;
      repeat (cyc) @(posedge clk_sys_i);
      #1 rst_pin_o = 1'h1;
   endtask
   task automatic set_trap(input logic lvl);
      @(posedge clk_sys_i) #1 trap_pin_o = lvl;
   endtask
endmodule // ext_src

/* dv/reset_trap_powerdown_ctrl_tb_top.sv */
// testbench: cycle model of reset qualifier, trap edge and power-down gate
`timescale 1ns/1ps
module reset_trap_powerdown_ctrl_tb_top;
   import rst_trap_pkg::*;
   logic        clk_sys_i = 1'h0;
   logic        resetn_i  = 1'h0;
   logic        pd_i      = 1'h0;
   logic        wake_i    = 1'h0;
   logic        rst_pin, trap_pin, s1, s2, t1, t2, t3;
   logic [31:0] rnd       = 32'h38;
   ctrl_out_s   ctrl_o, exp_s;
   int          cnt, err_count = 0, samples_checked = 0;
   always #4 clk_sys_i = ~clk_sys_i;
   ext_src src_u (.clk_sys_i(clk_sys_i), .rst_pin_o(rst_pin), .trap_pin_o(trap_pin));
   reset_trap_powerdown_ctrl dut_u (
      .clk_sys_i               (clk_sys_i),
      .resetn_i                (resetn_i),
      .reset_input_low_i       (rst_pin),
      .urgent_trap_n_i         (trap_pin),
      .power_down_instruction_i(pd_i),
      .wakeup_i                (wake_i),
      .ctrl_o                  (ctrl_o)
   );
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic check(input string nm, input logic [3:0] seen, input logic [3:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic pulse_pd();
      @(posedge clk_sys_i) #1 pd_i = 1'h1;
      @(posedge clk_sys_i) #1 pd_i = 1'h0;
   endtask
   // reference model: two-flop sync, low counter, edge and level decisions
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         {s1, s2, t1, t2, t3} <= 5'h1F;
         cnt <= 0;
         exp_s <= '0;
      end else begin
         {s1, s2, t1, t2, t3} <= {rst_pin, s1, trap_pin, t1, t2};
         cnt <= s2 ? 0 : cnt + 1;
         exp_s.reset_req <= !s2 && (cnt + 1 >= ACCEPT_CYC);
         exp_s.trap_req <= !t2 && t3 && !(!s2 && (cnt + 1 >= ACCEPT_CYC));
         exp_s.pd_ignored <= pd_i && t2 && !exp_s.power_down && !exp_s.reset_req;
         if (!s2 && (cnt + 1 >= ACCEPT_CYC)) exp_s.power_down <= 1'h0;
         else if (wake_i) exp_s.power_down <= 1'h0;
         else if (pd_i && !t2 && !exp_s.reset_req) exp_s.power_down <= 1'h1;
      end
   end
   always @(negedge clk_sys_i) if (resetn_i) check("ctrl", ctrl_o, exp_s);
   initial begin
      #100us;
      err_count++;
      stop_test();
   end
   initial begin
      repeat (5) @(posedge clk_sys_i);
      #1 resetn_i = 1'h1;
      for (int i = 0; i < 6; i++) begin
         rnd = xs(rnd);
         src_u.hold_reset(1 + int'(rnd % 32'(ACCEPT_CYC - 1)));
         repeat (6) @(posedge clk_sys_i);
      end
      src_u.hold_reset(ACCEPT_CYC - 1);
      src_u.hold_reset(ACCEPT_CYC);
      src_u.hold_reset(ACCEPT_CYC + 8);
      repeat (6) @(posedge clk_sys_i);
      pulse_pd();
      src_u.set_trap(1'h0);
      repeat (4) @(posedge clk_sys_i);
      // instruction with trap low, repeat ignored
      pulse_pd();
      pulse_pd();
      @(posedge clk_sys_i) #1 wake_i = 1'h1;
      @(posedge clk_sys_i) #1 wake_i = 1'h0;
      src_u.set_trap(1'h1);
      repeat (4) @(posedge clk_sys_i);
      pulse_pd();
      repeat (4) @(posedge clk_sys_i);
      // trap edge while held in reset is masked
      fork
         src_u.hold_reset(ACCEPT_CYC + 10);
         begin
            repeat (ACCEPT_CYC + 6) @(posedge clk_sys_i);
            src_u.set_trap(1'h0);
         end
      join
      repeat (6) @(posedge clk_sys_i);
      stop_test();
   end
endmodule // reset_trap_powerdown_ctrl_tb_top
